// >>> focr_top.sv
// ramp angle generator, angle compensation, pi limits and result read-back
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module focr_top #(
  parameter int unsigned ADDR_W = 32,
  parameter int unsigned PWM_DIV = focr_pkg::PWM_CYCLES
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // engine results
  input  wire logic signed [15:0] est_angle,
  input  wire logic signed [15:0] forced_angle,
  input  wire logic signed [15:0] d_pi_raw,
  input  wire logic signed [15:0] q_pi_raw,
  input  wire logic signed [15:0] park_d_current,
  input  wire logic signed [15:0] park_q_current,
  input  wire logic signed [15:0] beta_current_in,
  input  wire logic signed [15:0] ipark_alpha_voltage,
  input  wire logic signed [15:0] ipark_beta_voltage,
  input  wire logic signed [15:0] phase_a_sample,
  input  wire logic signed [15:0] phase_b_sample,
  input  wire logic signed [15:0] phase_c_sample,
  // angle and voltage outputs
  output logic signed [15:0]      output_angle,
  output logic signed [15:0]      d_voltage_out,
  output logic signed [15:0]      q_voltage_out,
  output logic                    ramp_active,
  output logic                    pwm_update
);
  import focr_pkg::*;

  typedef struct packed {
    logic [31:0] ramp_speed_accum;
    logic [15:0] ramp_acceleration;
    logic [7:0]  ramp_count_limit;
    logic [7:0]  angle_switch_step;
    logic [15:0] angle_offset_comp;
    logic [15:0] d_axis_out_max;
    logic [15:0] d_axis_out_min;
    logic [15:0] q_axis_out_max;
    logic [15:0] q_axis_out_min;
    logic [15:0] d_axis_voltage;
    logic [15:0] q_axis_voltage;
    logic [15:0] d_axis_current;
    logic [15:0] q_axis_current;
    logic [15:0] beta_current;
    logic [15:0] beta_voltage;
    logic [15:0] alpha_voltage;
    logic [15:0] phase_c_current;
    logic [15:0] phase_b_current;
    logic [15:0] phase_a_current;
    logic [15:0] open_loop_angle;
    logic [15:0] ramp_count;
    logic        ramp_angle_enable;
    logic        angle_source_select;
    logic        d_pi_freeze;
    logic        q_pi_freeze;
    focr_mode_t  mode;
    logic [15:0] angle;
    logic [31:0] rdata;
    logic        err;
  } focr_regs_t;

  focr_regs_t s;
  focr_regs_t next_s;

  logic              tick;
  logic [15:0]       idx;
  logic [15:0]       rel;
  logic              mapped;
  logic              is_ctrl;
  logic              wr_en;
  logic [7:0]        wbyte;
  logic              wr_hi;
  logic [4:0]        word;
  logic signed [15:0] comp_angle;
  logic signed [15:0] target;
  logic signed [15:0] diff;
  logic [15:0]       mag;
  logic [15:0]       ramp_end;

  focr_lim_if d_lim ();
  focr_lim_if q_lim ();

  focr_tick #(
    .DIV (PWM_DIV)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  assign d_lim.raw = d_pi_raw;
  assign d_lim.hi  = s.d_axis_out_max;
  assign d_lim.lo  = s.d_axis_out_min;
  assign q_lim.raw = q_pi_raw;
  assign q_lim.hi  = s.q_axis_out_max;
  assign q_lim.lo  = s.q_axis_out_min;

  focr_clamp u_d_clamp (
    .l (d_lim.lim_side)
  );

  focr_clamp u_q_clamp (
    .l (q_lim.lim_side)
  );

  // byte register decode; word aligned, one byte per word
  // address bits above 17 are not decoded, so the map repeats further up
  assign idx     = paddr[17:2];
  assign rel     = idx - IDX_RAMP_SPEED;
  assign is_ctrl = (idx == IDX_CTRL);
  assign mapped  = (paddr[1:0] == 2'b00) && ((rel < 16'(2 * REG_WORDS)) || is_ctrl);
  assign word    = rel[5:1];
  assign wr_hi   = !rel[0];
  assign wbyte   = pwdata[7:0];
  assign wr_en   = psel && penable && pwrite && mapped;

  // angle of the estimator shifted by the compensation value
  assign comp_angle = est_angle + s.angle_offset_comp;
  // source select low picks the forced pulling angle
  assign target     = s.angle_source_select ? comp_angle : forced_angle;
  assign diff       = target - s.open_loop_angle;
  // a gap of exactly half a turn keeps its sign and is stepped downward
  assign mag        = diff[15] ? 16'(-diff) : diff;
  // limit times 256 fits in 16 bits, so the counter never wraps before the end
  assign ramp_end   = {s.ramp_count_limit, 8'h00};

  function automatic logic [15:0] put_byte(input logic [15:0] old,
                                            input logic hi,
                                            input logic [7:0] b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : put_byte

  // words above 9 are engine results; the write case has no arm for them
  function automatic logic [15:0] word_of(input focr_regs_t r, input logic [4:0] w);
    case (w)
      5'h00:   word_of = r.ramp_speed_accum[31:16];
      5'h01:   word_of = r.ramp_acceleration;
      5'h02:   word_of = {r.ramp_count_limit, r.angle_switch_step};
      5'h03:   word_of = r.angle_offset_comp;
      5'h04:   word_of = r.d_axis_out_max;
      5'h05:   word_of = r.d_axis_out_min;
      5'h06:   word_of = r.q_axis_out_max;
      5'h07:   word_of = r.q_axis_out_min;
      5'h08:   word_of = r.d_axis_voltage;
      5'h09:   word_of = r.q_axis_voltage;
      5'h0a:   word_of = r.d_axis_current;
      5'h0b:   word_of = r.q_axis_current;
      5'h0c:   word_of = r.beta_current;
      5'h0d:   word_of = r.beta_voltage;
      5'h0e:   word_of = r.alpha_voltage;
      5'h0f:   word_of = r.phase_c_current;
      5'h10:   word_of = r.phase_b_current;
      5'h11:   word_of = r.phase_a_current;
      default: word_of = RST_WORD;
    endcase
  endfunction : word_of

  always_comb begin
    logic [15:0] rw;
    rw     = word_of(s, word);
    next_s = s;

    // read data is captured in the setup cycle so prdata leaves a flop
    if (psel && !penable) begin
      next_s.err = !mapped;
      if (!mapped) begin
        next_s.rdata = '0;
      end else if (is_ctrl) begin
        next_s.rdata = {28'h0000000, s.q_pi_freeze, s.d_pi_freeze,
                        s.angle_source_select, s.ramp_angle_enable};
      end else begin
        next_s.rdata = {24'h000000, wr_hi ? rw[15:8] : rw[7:0]};
      end
    end

    // engine results sampled once per pwm cycle
    // a frozen axis keeps its voltage, so software can hold a fixed value there
    if (tick) begin
      next_s.d_axis_current  = park_d_current;
      next_s.q_axis_current  = park_q_current;
      next_s.alpha_voltage   = ipark_alpha_voltage;
      next_s.beta_voltage    = ipark_beta_voltage;
      next_s.phase_a_current = phase_a_sample;
      next_s.phase_b_current = phase_b_sample;
      next_s.phase_c_current = phase_c_sample;
      next_s.beta_current    = beta_current_in;
      if (!s.d_pi_freeze) begin
        next_s.d_axis_voltage = d_lim.lim;
      end
      if (!s.q_pi_freeze) begin
        next_s.q_axis_voltage = q_lim.lim;
      end
    end

    // angle sequencer
    case (s.mode)
      FOCR_FOLLOW: begin
        next_s.open_loop_angle = target;
      end
      FOCR_RAMP: begin
        // the angle takes the speed from before this update's acceleration
        if (tick) begin
          next_s.ramp_speed_accum = s.ramp_speed_accum
                                    + {17'h00000, s.ramp_acceleration[14:0]};
          next_s.open_loop_angle  = s.open_loop_angle
                                    + s.ramp_speed_accum[31:16];
          next_s.ramp_count       = s.ramp_count + 1'b1;
          // the end test follows the add, so a zero limit still runs one update
          if (s.ramp_count + 16'h0001 >= ramp_end) begin
            next_s.ramp_angle_enable = 1'b0;
            next_s.mode              = FOCR_SWITCH;
          end
        end
      end
      FOCR_SWITCH: begin
        if (tick) begin
          // within one step it snaps; otherwise the signed gap picks the shorter way round
          if (mag <= {8'h00, s.angle_switch_step}) begin
            next_s.open_loop_angle = target;
            next_s.mode            = FOCR_FOLLOW;
          end else if (diff[15]) begin
            next_s.open_loop_angle = s.open_loop_angle
                                     - {8'h00, s.angle_switch_step};
          end else begin
            next_s.open_loop_angle = s.open_loop_angle
                                     + {8'h00, s.angle_switch_step};
          end
        end
      end
      default: begin
        next_s.mode = FOCR_FOLLOW;
      end
    endcase

    // software writes come last so they win over the same-cycle update
    if (wr_en) begin
      if (is_ctrl) begin
        // this write beats the hardware clear at ramp end in the same cycle
        next_s.ramp_angle_enable   = wbyte[CTRL_RAMP_EN];
        next_s.angle_source_select = wbyte[CTRL_SRC_SEL];
        next_s.d_pi_freeze         = wbyte[CTRL_D_FREEZE];
        next_s.q_pi_freeze         = wbyte[CTRL_Q_FREEZE];
        if (wbyte[CTRL_RAMP_EN] && !s.ramp_angle_enable) begin
          // a fresh ramp starts from the angle now being driven
          next_s.mode            = FOCR_RAMP;
          next_s.ramp_count      = '0;
          next_s.open_loop_angle = s.angle;
        end else if (!wbyte[CTRL_RAMP_EN] && s.mode == FOCR_RAMP) begin
          next_s.mode = FOCR_SWITCH;
        end
      end else begin
        case (word)
          5'h00: begin
            // either speed byte clears the fraction, so a new speed starts clean
            next_s.ramp_speed_accum = {put_byte(s.ramp_speed_accum[31:16], wr_hi, wbyte),
                                       16'h0000};
          end
          5'h01: begin
            next_s.ramp_acceleration = put_byte(s.ramp_acceleration, wr_hi, wbyte)
                                       & {1'b0, ACCEL_MASK};
          end
          5'h02: begin
            if (wr_hi) begin
              next_s.ramp_count_limit = wbyte;
            end else begin
              next_s.angle_switch_step = wbyte | SW_STEP_RO;
            end
          end
          5'h03: next_s.angle_offset_comp = put_byte(s.angle_offset_comp, wr_hi, wbyte);
          5'h04: next_s.d_axis_out_max = put_byte(s.d_axis_out_max, wr_hi, wbyte);
          5'h05: next_s.d_axis_out_min = put_byte(s.d_axis_out_min, wr_hi, wbyte);
          5'h06: next_s.q_axis_out_max = put_byte(s.q_axis_out_max, wr_hi, wbyte);
          5'h07: next_s.q_axis_out_min = put_byte(s.q_axis_out_min, wr_hi, wbyte);
          5'h08: next_s.d_axis_voltage = put_byte(s.d_axis_voltage, wr_hi, wbyte);
          5'h09: next_s.q_axis_voltage = put_byte(s.q_axis_voltage, wr_hi, wbyte);
          default: begin
            // writes to read-only results are dropped without an error
            next_s.err = s.err;
          end
        endcase
      end
    end

    // angle handed to the vector stage
    if (s.mode == FOCR_FOLLOW) begin
      next_s.angle = target;
    end else begin
      next_s.angle = s.open_loop_angle;
    end
  end

  // only the step register leaves reset non-zero; its bit 0 reads as one anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s                   <= '0;
      s.angle_switch_step <= RST_SW_STEP;
      s.mode              <= FOCR_FOLLOW;
    end else begin
      s <= next_s;
    end
  end

  assign prdata        = s.rdata;
  assign pslverr       = s.err && psel && penable;
  // no wait states: read data sits in its flop since the setup cycle
  assign pready        = psel && penable;
  assign output_angle  = s.angle;
  assign d_voltage_out = s.d_axis_voltage;
  assign q_voltage_out = s.q_axis_voltage;
  assign ramp_active   = s.ramp_angle_enable;
  assign pwm_update    = tick;
endmodule : focr_top

// >>> focr_pkg.sv
// shared constants, register map and types of the ramp angle and pi result block
package focr_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned PWM_PERIOD_NS  = 62500;
  localparam int unsigned PWM_CYCLES     = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W          = 16;
  localparam int unsigned RAMP_CNT_SHIFT = 8;
  localparam int unsigned REG_WORDS      = 18;

  localparam logic [15:0] IDX_RAMP_SPEED = 16'h40a8;
  localparam logic [15:0] IDX_RAMP_ACCEL = 16'h40aa;
  localparam logic [15:0] IDX_RAMP_LIMIT = 16'h40ac;
  localparam logic [15:0] IDX_SW_STEP    = 16'h40ad;
  localparam logic [15:0] IDX_ANGLE_COMP = 16'h40ae;
  localparam logic [15:0] IDX_D_MAX      = 16'h40b0;
  localparam logic [15:0] IDX_D_MIN      = 16'h40b2;
  localparam logic [15:0] IDX_Q_MAX      = 16'h40b4;
  localparam logic [15:0] IDX_Q_MIN      = 16'h40b6;
  localparam logic [15:0] IDX_D_VOLT     = 16'h40b8;
  localparam logic [15:0] IDX_Q_VOLT     = 16'h40ba;
  localparam logic [15:0] IDX_D_CURR     = 16'h40bc;
  localparam logic [15:0] IDX_Q_CURR     = 16'h40be;
  localparam logic [15:0] IDX_BETA_CURR  = 16'h40c0;
  localparam logic [15:0] IDX_BETA_VOLT  = 16'h40c2;
  localparam logic [15:0] IDX_ALPHA_VOLT = 16'h40c4;
  localparam logic [15:0] IDX_PH_C_CURR  = 16'h40c6;
  localparam logic [15:0] IDX_PH_B_CURR  = 16'h40c8;
  localparam logic [15:0] IDX_PH_A_CURR  = 16'h40ca;
  localparam logic [15:0] IDX_CTRL       = 16'h40f0;

  localparam int unsigned CTRL_RAMP_EN   = 0;
  localparam int unsigned CTRL_SRC_SEL   = 1;
  localparam int unsigned CTRL_D_FREEZE  = 2;
  localparam int unsigned CTRL_Q_FREEZE  = 3;

  localparam logic [7:0]  RST_SW_STEP    = 8'h01;
  localparam logic [7:0]  SW_STEP_RO     = 8'h01;
  localparam logic [14:0] ACCEL_MASK     = 15'h7fff;
  localparam logic [15:0] RST_WORD       = 16'h0000;

  typedef enum logic [1:0] {
    FOCR_FOLLOW,
    FOCR_RAMP,
    FOCR_SWITCH
  } focr_mode_t;
endpackage : focr_pkg

// >>> focr_lim_if.sv
// carrier between the top and a pi output limiter
`timescale 1ns/1ns
interface focr_lim_if;
  logic signed [15:0] raw;
  logic signed [15:0] hi;
  logic signed [15:0] lo;
  logic signed [15:0] lim;
  modport user (output raw, output hi, output lo, input lim);
  modport lim_side (input raw, input hi, input lo, output lim);
endinterface : focr_lim_if

// >>> focr_clamp.sv
// saturating limiter for one pi controller axis
`timescale 1ns/1ns
module focr_clamp (
  // limiter values
  focr_lim_if.lim_side l
);
  // min is tested first; with an inverted pair a raw value at or above min gives max
  always_comb begin
    if (l.raw < l.lo) begin
      l.lim = l.lo;
    end else if (l.raw > l.hi) begin
      l.lim = l.hi;
    end else begin
      l.lim = l.raw;
    end
  end
endmodule : focr_clamp

// >>> focr_tick.sv
// divider that makes the once per pwm cycle update pulse
`timescale 1ns/1ns
module focr_tick #(
  parameter int unsigned DIV = focr_pkg::PWM_CYCLES
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // update pulse
  output logic      tick
);
  import focr_pkg::*;
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } focr_tick_t;
  focr_tick_t s;
  focr_tick_t next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (s.cnt == DIV_W'(DIV - 1)) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : focr_tick

// >>> focr_chk.sv
// assertion checker bound to the top of the ramp angle and pi result block
`timescale 1ns/1ns
module focr_chk #(
  parameter int unsigned PWM_DIV = focr_pkg::PWM_CYCLES
) (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb slave
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // outputs
  input wire logic signed [15:0] d_voltage_out,
  input wire logic signed [15:0] q_voltage_out,
  input wire logic               ramp_active,
  input wire logic               pwm_update
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] gap;
  logic        seen;
  logic        wr_acc;
  assign wr_acc = psel && penable && pwrite;
  // first pulse after reset is not spaced against anything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap  <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap  <= pwm_update ? 16'h0000 : gap + 16'h0001;
      seen <= seen | pwm_update;
    end
  end
  property p_tick; pwm_update && seen |-> gap == 16'(PWM_DIV - 1); endproperty
  a_tick: assert property (p_tick) else $error("update pulse spacing wrong");
  property p_rdy; pready == (psel && penable); endproperty
  a_rdy: assert property (p_rdy) else $error("ready not in access cycle");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("read data above byte");
  property p_ron; $rose(ramp_active) |-> $past(wr_acc); endproperty
  a_ron: assert property (p_ron) else $error("ramp started without write");
  property p_roff; $fell(ramp_active) |-> $past(pwm_update) || $past(wr_acc); endproperty
  a_roff: assert property (p_roff) else $error("ramp ended off update");
  property p_dv; $changed(d_voltage_out) |-> $past(pwm_update) || $past(wr_acc); endproperty
  a_dv: assert property (p_dv) else $error("d voltage changed off update");
  property p_qv; $changed(q_voltage_out) |-> $past(pwm_update) || $past(wr_acc); endproperty
  a_qv: assert property (p_qv) else $error("q voltage changed off update");
  c_ron: cover property ($rose(ramp_active));
  c_roff: cover property ($fell(ramp_active));
  c_err: cover property (pslverr);
  c_dv: cover property ($changed(d_voltage_out));
endmodule : focr_chk

bind focr_top focr_chk #(.PWM_DIV(PWM_DIV)) focr_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .d_voltage_out(d_voltage_out),
  .q_voltage_out(q_voltage_out), .ramp_active(ramp_active), .pwm_update(pwm_update)
);

// >>> focr_top_tb.sv
// self-checking bench for the ramp angle and pi result block
`timescale 1ns/1ns
module focr_top_tb;
  import focr_pkg::*;
  localparam int unsigned DIV = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ramp_active, pwm_update, probe;
  logic [31:0]        paddr, pwdata, prdata, acc;
  logic signed [15:0] est_angle, forced_angle, d_pi_raw, q_pi_raw, output_angle, smp [8];
  logic signed [15:0] d_voltage_out, q_voltage_out;
  logic [15:0]        v, ang, dif;
  logic [34:0]        exp_q [$];
  logic [34:0]        e;
  logic [32:0]        got;
  int                 err_total, comparisons;
  logic [15:0] sidx [8] = '{IDX_D_CURR, IDX_Q_CURR, IDX_BETA_CURR, IDX_ALPHA_VOLT,
                            IDX_BETA_VOLT, IDX_PH_A_CURR, IDX_PH_B_CURR, IDX_PH_C_CURR};

  focr_top #(.PWM_DIV(DIV)) focr_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .est_angle(est_angle), .forced_angle(forced_angle), .d_pi_raw(d_pi_raw),
    .q_pi_raw(q_pi_raw), .park_d_current(smp[0]), .park_q_current(smp[1]),
    .beta_current_in(smp[2]), .ipark_alpha_voltage(smp[3]), .ipark_beta_voltage(smp[4]),
    .phase_a_sample(smp[5]), .phase_b_sample(smp[6]), .phase_c_sample(smp[7]),
    .output_angle(output_angle), .d_voltage_out(d_voltage_out),
    .q_voltage_out(q_voltage_out), .ramp_active(ramp_active), .pwm_update(pwm_update)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // a read pops its note in the access cycle, a probe one cycle after it is raised
  always @(posedge pclk) begin
    if ((psel && penable && !pwrite) || probe) begin
      e = exp_q.pop_front();
      case (e[34:33])
        2'd0: got = {pslverr, prdata};
        2'd1: got = {16'h0, ramp_active, output_angle};
        2'd2: got = {17'h0, d_voltage_out};
        default: got = {17'h0, q_voltage_out};
      endcase
      comparisons++;
      if (got !== e[32:0]) begin
        err_total++;
        $display("unexpected at %0t: got %h expected %h", $time, got, e[32:0]);
      end
    end
  end

  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {14'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      print_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic er = 1'b0);
    exp_q.push_back({2'd0, er, 24'h0, d});
    xfer(1'b0, idx, 8'h00);
  endtask : rd

  task automatic w16(input logic [15:0] idx, input logic [15:0] d);
    wr(idx, d[15:8]);
    wr(idx + 16'h1, d[7:0]);
  endtask : w16

  task automatic r16(input logic [15:0] idx, input logic [15:0] d);
    rd(idx, d[15:8]);
    rd(idx + 16'h1, d[7:0]);
  endtask : r16

  task automatic pr(input logic [1:0] k, input logic [15:0] d, input logic r = 1'b0);
    exp_q.push_back({k, 16'h0, r, d});
    @(posedge pclk);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask : pr

  // returns one edge after the k-th update pulse
  task automatic upd(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 5000) begin
      @(posedge pclk);
      n++;
      if (pwm_update === 1'b1)
        k--;
    end
    if (n >= 5000) begin
      err_total++;
      print_verdict();
    end
    @(posedge pclk);
  endtask : upd

  initial begin
    {presetn, psel, penable, pwrite, probe, paddr, pwdata} = '0;
    {est_angle, forced_angle, d_pi_raw, q_pi_raw} = '0;
    foreach (smp[i]) smp[i] = 16'h0000;
    err_total = 0;
    comparisons = 0;
    void'($urandom(71899));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 16'h40a8; i < 16'h40cc; i++) begin
      rd(16'(i), (16'(i) == IDX_SW_STEP) ? RST_SW_STEP : 8'h00);
    end
    rd(16'h40d0, 8'h00, 1'b1);
    wr(IDX_D_CURR, 8'hff);
    rd(IDX_D_CURR, 8'h00);
    $display("reset and map test done");
    wr(IDX_CTRL, 8'h0c);
    for (int i = 16'h40a8; i < 16'h40bc; i += 2) begin
      v = 16'($urandom);
      if (i != 16'h40ac) w16(16'(i), v);
      if (i == 16'h40aa) v[15] = 1'b0;
      if (i != 16'h40ac) r16(16'(i), v);
    end
    wr(IDX_RAMP_LIMIT, 8'h5a);
    rd(IDX_RAMP_LIMIT, 8'h5a);
    wr(IDX_SW_STEP, 8'h00);
    rd(IDX_SW_STEP, 8'h01);
    $display("read write test done");
    for (int i = 0; i < 8; i++) smp[i] <= 16'($urandom);
    upd(1);
    for (int i = 0; i < 8; i++) r16(sidx[i], smp[i]);
    $display("sampled results test done");
    w16(IDX_D_MAX, 16'h0100);
    w16(IDX_D_MIN, 16'hff00);
    w16(IDX_Q_MAX, 16'h0200);
    w16(IDX_Q_MIN, 16'hfe00);
    wr(IDX_CTRL, 8'h00);
    d_pi_raw <= 16'h1234;
    q_pi_raw <= 16'h8000;
    upd(1);
    pr(2'd2, 16'h0100);
    pr(2'd3, 16'hfe00);
    d_pi_raw <= 16'h0042;
    q_pi_raw <= 16'hff07;
    upd(1);
    pr(2'd2, 16'h0042);
    pr(2'd3, 16'hff07);
    wr(IDX_CTRL, 8'h0c);
    d_pi_raw <= 16'h0010;
    upd(1);
    pr(2'd2, 16'h0042);
    w16(IDX_D_VOLT, 16'h5a5a);
    upd(1);
    pr(2'd2, 16'h5a5a);
    $display("limit and freeze test done");
    est_angle <= 16'h7f00;
    w16(IDX_ANGLE_COMP, 16'h0200);
    wr(IDX_CTRL, 8'h02);
    upd(1);
    pr(2'd1, 16'h8100);
    $display("compensation test done");
    forced_angle <= 16'h1000;
    w16(IDX_RAMP_SPEED, 16'h0123);
    w16(IDX_RAMP_ACCEL, 16'h1357);
    wr(IDX_RAMP_LIMIT, 8'h01);
    wr(IDX_SW_STEP, 8'h40);
    wr(IDX_CTRL, 8'h00);
    upd(1);
    pr(2'd1, 16'h1000);
    wr(IDX_CTRL, 8'h01);
    ang = 16'h1000;
    acc = 32'h01230000;
    for (int n = 1; n <= 256; n++) begin
      upd(1);
      ang = ang + acc[31:16];
      acc = acc + 32'h00001357;
      if (n < 3) pr(2'd1, ang, 1'b1);
      if (n < 3) r16(IDX_RAMP_SPEED, acc[31:16]);
      if (n == 255) rd(IDX_CTRL, 8'h01);
      if (n == 256) rd(IDX_CTRL, 8'h00);
    end
    pr(2'd1, ang);
    upd(1);
    dif = 16'h1000 - ang;
    if ($signed(dif) > 16'sd65 || $signed(dif) < -16'sd65)
      ang = ang + (($signed(dif) > 0) ? 16'h0041 : 16'hffbf);
    else
      ang = 16'h1000;
    pr(2'd1, ang);
    $display("ramp and switch test done");
    print_verdict();
  end
endmodule : focr_top_tb
